// ===== rtl/ctbank_pkg.sv
/*
  Constants for the bank-switched counter/timer window: offsets, field positions,
  bank key nibbles and mode codes.
  Assumes an ISA-style byte/word I/O decode already qualified by board select.
*/
package ctbank_pkg;
  localparam logic [3:0] CTB_OFS_ADC_CFG = 4'hb;
  localparam logic [3:0] CTB_OFS_DATA_LO = 4'hc;
  localparam logic [3:0] CTB_OFS_DATA_HI = 4'hd;
  localparam logic [3:0] CTB_OFS_POINTER = 4'he;
  localparam logic [3:0] CTB_OFS_CONTROL = 4'hf;
  localparam int CTB_BANK_BIT = 7;
  localparam logic [3:0] CTB_KEY_IDX_A = 4'hf;
  localparam logic [3:0] CTB_KEY_IDX_B = 4'h5;
  localparam logic [3:0] CTB_KEY_IDX_C = 4'hd;
  localparam logic [3:0] CTB_KEY_CNT_A = 4'h3;
  localparam logic [3:0] CTB_KEY_CNT_B = 4'hb;
  localparam logic [3:0] CTB_KEY_CNT_C = 4'ha;
  localparam logic [7:0] CTB_POINTER_RST = 8'h00;
  localparam logic [7:0] CTB_WORD_STEP = 8'h02;
  localparam logic [7:0] CTB_BYTE_STEP = 8'h01;
  localparam logic [1:0] CTB_SEL_READBACK = 2'h3;
  typedef enum logic [1:0] {
    CTB_ACC_LATCH = 2'h0, CTB_ACC_LOW = 2'h1, CTB_ACC_HIGH = 2'h2, CTB_ACC_BOTH = 2'h3
  } ctb_access_type;
  typedef enum logic [5:0] {
    CTB_MODE_TERM = 6'h01, CTB_MODE_ONESHOT = 6'h02, CTB_MODE_RATE = 6'h04,
    CTB_MODE_SQUARE = 6'h08, CTB_MODE_SSTROBE = 6'h10, CTB_MODE_HSTROBE = 6'h20
  } ctb_mode_type;
endpackage

// ===== rtl/ctbank_key.sv
/*
  Bank key sequence detector: watches upper nibbles of ADC configuration writes.
  Assumes one write strobe per bus cycle on the reference clock.
*/
`timescale 1ns/1ps
module ctbank_key
  import ctbank_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Configuration write
  input wire logic cfg_wr_i,
  input wire logic [3:0] bank_key_nibble_i,
  // Bank
  output logic bank_status_o
);
  logic [1:0] idx_step_r, idx_step_nxt, cnt_step_r, cnt_step_nxt;
  logic bank_r, bank_nxt;

  // ----------------------------------------
  // Sequence tracking
  // ----------------------------------------
  // A wrong nibble restarts, but a repeated first key counts as a fresh start,
  // so F,F,5,D still works as the host driver writes it.
  function automatic logic [1:0] ctb_step(input logic [1:0] st, input logic [3:0] nib,
                                          input logic [3:0] ka, input logic [3:0] kb);
    if (st == 2'h1 && nib == kb) begin
      ctb_step = 2'h2;
    end else if (nib == ka) begin
      ctb_step = 2'h1;
    end else begin
      ctb_step = 2'h0;
    end
  endfunction

  always_comb begin
    idx_step_nxt = idx_step_r;
    cnt_step_nxt = cnt_step_r;
    bank_nxt = bank_r;
    if (cfg_wr_i) begin
      idx_step_nxt = ctb_step(idx_step_r, bank_key_nibble_i, CTB_KEY_IDX_A, CTB_KEY_IDX_B);
      cnt_step_nxt = ctb_step(cnt_step_r, bank_key_nibble_i, CTB_KEY_CNT_A, CTB_KEY_CNT_B);
      if (idx_step_r == 2'h2 && bank_key_nibble_i == CTB_KEY_IDX_C) begin
        bank_nxt = 1'b1;
        idx_step_nxt = 2'h0;
      end
      if (cnt_step_r == 2'h2 && bank_key_nibble_i == CTB_KEY_CNT_C) begin
        bank_nxt = 1'b0;
        cnt_step_nxt = 2'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      idx_step_r <= 2'h0;
      cnt_step_r <= 2'h0;
      bank_r <= 1'b0;
    end else begin
      idx_step_r <= idx_step_nxt;
      cnt_step_r <= cnt_step_nxt;
      bank_r <= bank_nxt;
    end
  end

  assign bank_status_o = bank_r;
endmodule

// ===== rtl/ctbank_port.sv
/*
  Bank-switched I/O window at offsets 12 to 15: counter data/control bytes in
  bank 0, indexed data port and pointer in bank 1.
  Assumes the host bus is already synchronous to ref_clk_i: one-cycle write and
  read strobes, with word_i marking a 16-bit cycle. The counters and the indexed
  array live outside; this block only decodes and steers.
*/
`timescale 1ns/1ps
module ctbank_port
  import ctbank_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Host I/O cycle
  input wire logic [3:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic io_word_i,
  input wire logic [15:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  // Other ADC configuration bits, read back below the bank flag
  input wire logic [6:0] adc_cfg_low_i,
  input wire logic auto_advance_inhibit_i,
  // Counter side
  output logic [2:0] counter_wr_o,
  output logic [2:0] counter_rd_o,
  output logic [7:0] counter_wdata_o,
  input wire logic [7:0] counter0_data_byte_i,
  input wire logic [7:0] counter1_data_byte_i,
  input wire logic [7:0] counter2_data_byte_i,
  output logic counter_ctrl_wr_o,
  output logic [1:0] counter_target_select_o,
  output logic [1:0] counter_access_o,
  output logic [5:0] counter_mode_o,
  output logic counter_decimal_o,
  output logic counter_readback_o,
  // Indexed array side
  output logic array_wr_o,
  output logic array_rd_o,
  output logic [1:0] array_lanes_o,
  output logic [7:0] array_addr_o,
  output logic [15:0] array_wdata_o,
  input wire logic [15:0] array_rdata_i,
  // Bank state
  output logic bank_status_o
);
  logic bank;
  logic in_window;
  logic cfg_wr;
  logic [7:0] ptr_r, ptr_nxt;
  logic [1:0] sel_r, sel_nxt, acc_r, acc_nxt;
  logic [5:0] mode_r, mode_nxt;
  logic dec_r, dec_nxt, rbk_r, rbk_nxt, cwr_r, cwr_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [2:0] cwr_port_r, cwr_port_nxt, crd_port_r, crd_port_nxt;
  logic [7:0] cwdata_r, cwdata_nxt;
  logic awr_r, awr_nxt, ard_r, ard_nxt;
  logic [1:0] lanes_r, lanes_nxt;
  logic [15:0] awdata_r, awdata_nxt;
  logic [7:0] aaddr_r, aaddr_nxt;
  logic data_hit;

  // ----------------------------------------
  // Bank key detector
  // ----------------------------------------
  assign cfg_wr = io_wr_i && io_addr_i == CTB_OFS_ADC_CFG;
  ctbank_key u_key (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .cfg_wr_i(cfg_wr),
    .bank_key_nibble_i(io_wdata_i[7:4]),
    .bank_status_o(bank)
  );

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [5:0] ctb_mode(input logic [2:0] m);
    case (m[1:0])
      2'h2: ctb_mode = CTB_MODE_RATE;
      2'h3: ctb_mode = CTB_MODE_SQUARE;
      2'h0: ctb_mode = m[2] ? CTB_MODE_SSTROBE : CTB_MODE_TERM;
      default: ctb_mode = m[2] ? CTB_MODE_HSTROBE : CTB_MODE_ONESHOT;
    endcase
  endfunction

  // Only offsets 12..15 see the bank; everything else passes unchanged.
  assign in_window = io_addr_i[3:2] == CTB_OFS_DATA_LO[3:2];
  assign data_hit = bank && io_addr_i == CTB_OFS_DATA_LO;

  // ----------------------------------------
  // Access steering
  // ----------------------------------------
  always_comb begin
    ptr_nxt = ptr_r;
    sel_nxt = sel_r;
    acc_nxt = acc_r;
    mode_nxt = mode_r;
    dec_nxt = dec_r;
    rbk_nxt = 1'b0;
    cwr_nxt = 1'b0;
    rdata_nxt = rdata_r;
    cwr_port_nxt = 3'h0;
    crd_port_nxt = 3'h0;
    cwdata_nxt = cwdata_r;
    awr_nxt = 1'b0;
    ard_nxt = 1'b0;
    lanes_nxt = lanes_r;
    awdata_nxt = awdata_r;
    aaddr_nxt = aaddr_r;
    if (io_rd_i && io_addr_i == CTB_OFS_ADC_CFG) begin
      rdata_nxt = {8'h00, bank, adc_cfg_low_i};
    end
    if ((io_wr_i || io_rd_i) && in_window) begin
      if (!bank) begin
        // Counter bank: 12..14 data bytes, 15 control byte
        if (io_addr_i == CTB_OFS_CONTROL) begin
          if (io_wr_i) begin
            sel_nxt = io_wdata_i[7:6];
            acc_nxt = io_wdata_i[5:4];
            mode_nxt = ctb_mode(io_wdata_i[3:1]);
            dec_nxt = io_wdata_i[0];
            rbk_nxt = io_wdata_i[7:6] == CTB_SEL_READBACK;
            cwr_nxt = 1'b1;
          end
        end else begin
          cwdata_nxt = io_wdata_i[7:0];
          cwr_port_nxt[io_addr_i[1:0]] = io_wr_i;
          crd_port_nxt[io_addr_i[1:0]] = io_rd_i;
          if (io_rd_i) begin
            case (io_addr_i[1:0])
              2'h0: rdata_nxt = {8'h00, counter0_data_byte_i};
              2'h1: rdata_nxt = {8'h00, counter1_data_byte_i};
              default: rdata_nxt = {8'h00, counter2_data_byte_i};
            endcase
          end
        end
      end else if (io_addr_i == CTB_OFS_POINTER) begin
        if (io_wr_i) begin
          ptr_nxt = io_wdata_i[7:0];
        end
        if (io_rd_i) begin
          rdata_nxt = {8'h00, ptr_r};
        end
      end else if (data_hit || io_addr_i == CTB_OFS_DATA_HI) begin
        // Indexed array replaces the counter bytes
        awr_nxt = io_wr_i;
        ard_nxt = io_rd_i;
        aaddr_nxt = ptr_r;
        if (io_word_i && data_hit) begin
          lanes_nxt = 2'h3;
          awdata_nxt = io_wdata_i;
          if (io_rd_i) begin
            rdata_nxt = array_rdata_i;
          end
          if (!auto_advance_inhibit_i) begin
            ptr_nxt = ptr_r + CTB_WORD_STEP;
          end
        end else begin
          lanes_nxt = data_hit ? 2'h1 : 2'h2;
          awdata_nxt = {io_wdata_i[7:0], io_wdata_i[7:0]};
          if (io_rd_i) begin
            rdata_nxt = {8'h00, data_hit ? array_rdata_i[7:0] : array_rdata_i[15:8]};
          end
          if (!auto_advance_inhibit_i) begin
            ptr_nxt = ptr_r + CTB_BYTE_STEP;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ptr_r <= CTB_POINTER_RST;
      sel_r <= 2'h0;
      acc_r <= 2'h0;
      mode_r <= CTB_MODE_TERM;
      dec_r <= 1'b0;
      rbk_r <= 1'b0;
      cwr_r <= 1'b0;
      rdata_r <= 16'h0000;
      cwr_port_r <= 3'h0;
      crd_port_r <= 3'h0;
      cwdata_r <= 8'h00;
      awr_r <= 1'b0;
      ard_r <= 1'b0;
      lanes_r <= 2'h0;
      awdata_r <= 16'h0000;
      aaddr_r <= 8'h00;
    end else begin
      ptr_r <= ptr_nxt;
      sel_r <= sel_nxt;
      acc_r <= acc_nxt;
      mode_r <= mode_nxt;
      dec_r <= dec_nxt;
      rbk_r <= rbk_nxt;
      cwr_r <= cwr_nxt;
      rdata_r <= rdata_nxt;
      cwr_port_r <= cwr_port_nxt;
      crd_port_r <= crd_port_nxt;
      cwdata_r <= cwdata_nxt;
      awr_r <= awr_nxt;
      ard_r <= ard_nxt;
      lanes_r <= lanes_nxt;
      awdata_r <= awdata_nxt;
      aaddr_r <= aaddr_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign io_rdata_o = rdata_r;
  assign counter_wr_o = cwr_port_r;
  assign counter_rd_o = crd_port_r;
  assign counter_wdata_o = cwdata_r;
  assign counter_ctrl_wr_o = cwr_r;
  assign counter_target_select_o = sel_r;
  assign counter_access_o = acc_r;
  assign counter_mode_o = mode_r;
  assign counter_decimal_o = dec_r;
  assign counter_readback_o = rbk_r;
  assign array_wr_o = awr_r;
  assign array_rd_o = ard_r;
  assign array_lanes_o = lanes_r;
  assign array_addr_o = aaddr_r;
  assign array_wdata_o = awdata_r;
  assign bank_status_o = bank;
endmodule

// ===== tb/ctbank_chk.sv
/*
  Port checker for the bank-switched counter/timer window.
  Assumes it is bound into ctbank_port and sees only that module's ports.
*/
`timescale 1ns/1ps
module ctbank_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Host cycle
  input wire logic [3:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic io_word_i,
  input wire logic [15:0] io_wdata_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic [6:0] adc_cfg_low_i,
  input wire logic auto_advance_inhibit_i,
  // Counter side
  input wire logic [2:0] counter_wr_o,
  input wire logic [7:0] counter_wdata_o,
  input wire logic counter_ctrl_wr_o,
  input wire logic [1:0] counter_target_select_o,
  input wire logic [1:0] counter_access_o,
  input wire logic [5:0] counter_mode_o,
  input wire logic counter_decimal_o,
  input wire logic counter_readback_o,
  // Array side and bank
  input wire logic array_wr_o,
  input wire logic [1:0] array_lanes_o,
  input wire logic [7:0] array_addr_o,
  input wire logic [15:0] array_wdata_o,
  input wire logic bank_status_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic ctl, kw, acc, arr, w12;
  assign ctl = io_wr_i && io_addr_i == 4'hf && !bank_status_o;
  assign kw = io_wr_i && io_addr_i == 4'hb;
  assign acc = io_wr_i && bank_status_o && io_addr_i inside {4'hc, 4'hd};
  assign arr = acc && !auto_advance_inhibit_i;
  assign w12 = io_word_i && io_addr_i == 4'hc;
  function automatic logic [5:0] mode_of(input logic [2:0] m);
    if (m[1]) return m[0] ? 6'h08 : 6'h04;
    return 6'h01 << {m[2], 1'b0, m[0]};
  endfunction
  a_ctrl_fields: assert property (ctl |=> counter_ctrl_wr_o
    && {counter_target_select_o, counter_access_o, counter_decimal_o}
    == {$past(io_wdata_i[7:4]), $past(io_wdata_i[0])}
    && counter_readback_o == ($past(io_wdata_i[7:6]) == 2'h3)) else $error("bad ctrl");
  a_mode_decode: assert property (ctl |=>
    counter_mode_o == mode_of($past(io_wdata_i[3:1]))) else $error("bad mode");
  a_ctrl_bank1: assert property (io_wr_i && io_addr_i == 4'hf && bank_status_o
    |=> !counter_ctrl_wr_o && $stable(counter_mode_o)) else $error("ctrl in bank 1");
  a_cnt_write: assert property (io_wr_i && !bank_status_o && io_addr_i inside
    {4'hc, 4'hd, 4'he} |=> counter_wr_o == 3'h1 << ($past(io_addr_i) - 4'hc)
    && counter_wdata_o == $past(io_wdata_i[7:0])) else $error("bad counter write");
  a_bank1_steer: assert property (bank_status_o && io_wr_i && io_addr_i > 4'hb
    |=> counter_wr_o == 3'h0 && array_wr_o == $past(io_addr_i < 4'he)) else $error("steer");
  a_word_lanes: assert property (acc && w12 |=> array_lanes_o == 2'h3
    && array_wdata_o == $past(io_wdata_i)) else $error("bad word write");
  a_ptr_word: assert property (arr && w12 ##1 acc |=>
    array_addr_o == $past(array_addr_o) + 8'h02) else $error("word step");
  a_ptr_byte: assert property (arr && !w12 ##1 acc |=>
    array_addr_o == $past(array_addr_o) + 8'h01) else $error("byte step");
  a_key_enter: assert property (kw && io_wdata_i[7:4] == 4'hf ##1
    kw && io_wdata_i[7:4] == 4'h5 ##1 kw && io_wdata_i[7:4] == 4'hd |=> bank_status_o)
    else $error("no bank 1");
  a_key_exit: assert property (kw && io_wdata_i[7:4] == 4'h3 ##1
    kw && io_wdata_i[7:4] == 4'hb ##1 kw && io_wdata_i[7:4] == 4'ha |=> !bank_status_o)
    else $error("no bank 0");
  a_bank_cause: assert property ($changed(bank_status_o) |-> $past(kw))
    else $error("bank moved");
  a_cfg_read: assert property (io_rd_i && io_addr_i == 4'hb |=> io_rdata_o[7:0]
    == {$past(bank_status_o), $past(adc_cfg_low_i)}) else $error("bad cfg read");
  a_reset_state: assert property (disable iff (1'b0) rst_i |=>
    !bank_status_o && counter_mode_o == 6'h01) else $error("bad reset");
endmodule
bind ctbank_port ctbank_chk chk_u (.*);

// ===== tb/ctbank_host.sv
/*
  Host model issuing one-cycle I/O strobes on falling edges.
  Assumes the window samples requests on the rising edge.
*/
`timescale 1ns/1ps
module ctbank_host (
  // Clock
  input wire logic clk_i,
  // I/O cycle
  output logic [3:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic word_o,
  output logic [15:0] wdata_o
);
  initial begin
    {addr_o, wr_o, rd_o, word_o, wdata_o} = '0;
  end
  task cyc(input logic w, input logic [3:0] a, input logic wd, input logic [15:0] d);
    @(negedge clk_i);
    {wr_o, rd_o, addr_o, word_o, wdata_o} = {w, !w, a, wd, d};
  endtask
  // Released lines show inverted leftovers so stale values cannot pass
  task idle();
    @(negedge clk_i);
    {wr_o, rd_o} = 2'h0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  // First nibble sent twice, as host software does
  task bank(input logic b, input logic [3:0] low);
    logic [3:0] k [4];
    if (b) begin
      k = '{4'hf, 4'hf, 4'h5, 4'hd};
    end else begin
      k = '{4'h3, 4'h3, 4'hb, 4'ha};
    end
    foreach (k[i]) cyc(1'b1, 4'hb, 1'b0, {8'h00, k[i], low});
    idle();
  endtask
endmodule

// ===== tb/tb_top.sv
/*
  Self-checking bench for ctbank_port: table of counter-bank writes, then
  bank switching, indexed access and reset by hand.
*/
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i, rst_i, io_wr_i, io_rd_i, io_word_i;
  logic [3:0] io_addr_i;
  logic [15:0] io_wdata_i, io_rdata_o, array_wdata_o;
  logic [6:0] adc_cfg_low_i = 7'h2a;
  logic auto_advance_inhibit_i = 1'b0;
  logic [7:0] counter0_data_byte_i = 8'h11, counter1_data_byte_i = 8'h22;
  logic [7:0] counter2_data_byte_i = 8'h33, counter_wdata_o, array_addr_o;
  logic [15:0] array_rdata_i = 16'hcafe;
  logic [2:0] counter_wr_o, counter_rd_o;
  logic [1:0] counter_target_select_o, counter_access_o, array_lanes_o;
  logic [5:0] counter_mode_o;
  logic counter_ctrl_wr_o, counter_decimal_o, counter_readback_o;
  logic array_wr_o, array_rd_o, bank_status_o;
  int n_errors = 0, compares = 0;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [2:0] cw; logic [5:0] m;} ctb_row_type;
  ctb_row_type rows [11] = '{
    '{4'hc, 8'h5a, 3'h1, 6'h01}, '{4'hd, 8'ha5, 3'h2, 6'h01}, '{4'he, 8'h3c, 3'h4, 6'h01},
    '{4'hf, 8'h00, 3'h0, 6'h01}, '{4'hf, 8'h53, 3'h0, 6'h02}, '{4'hf, 8'ha4, 3'h0, 6'h04},
    '{4'hf, 8'hf6, 3'h0, 6'h08}, '{4'hf, 8'h39, 3'h0, 6'h10}, '{4'hf, 8'h6a, 3'h0, 6'h20},
    '{4'hf, 8'h8d, 3'h0, 6'h04}, '{4'hf, 8'hcf, 3'h0, 6'h08}};
  ctbank_port dut_u (.*);
  ctbank_host host_u (.clk_i(ref_clk_i), .addr_o(io_addr_i), .wr_o(io_wr_i),
    .rd_o(io_rd_i), .word_o(io_word_i), .wdata_o(io_wdata_i));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task op(input logic w, input logic [3:0] a, input logic wd, input logic [15:0] d);
    host_u.cyc(w, a, wd, d);
    host_u.idle();
  endtask
  task summarize();
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Whole run is under a hundred cycles
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    rst_i = 1'b0;
    op(1'b0, 4'hb, 1'b0, 16'h0000);
    chk("cfg", io_rdata_o[7:0], {1'b0, adc_cfg_low_i});
    foreach (rows[i]) begin
      op(1'b1, rows[i].a, 1'b0, {8'h00, rows[i].d});
      chk("cwr", counter_wr_o, rows[i].cw);
      chk("ctl", counter_ctrl_wr_o, rows[i].cw == 3'h0);
      chk("mode", counter_mode_o, rows[i].m);
      if (rows[i].cw == 3'h0) begin
        chk("fld", {counter_target_select_o, counter_access_o, counter_decimal_o,
          counter_readback_o}, {rows[i].d[7:4], rows[i].d[0], rows[i].d[7:6] == 2'h3});
      end else begin
        chk("cwd", counter_wdata_o, rows[i].d);
      end
    end
    for (int i = 0; i < 3; i++) begin
      op(1'b0, 4'hc + 4'(i), 1'b0, 16'h0000);
      chk("crd", {counter_rd_o, io_rdata_o[7:0]}, {3'h1 << i, 8'(8'h11 * (i + 1))});
    end
    host_u.cyc(1'b1, 4'hb, 1'b0, 16'h00f1);
    host_u.cyc(1'b1, 4'hb, 1'b0, 16'h0052);
    op(1'b1, 4'hb, 1'b0, 16'h00e3);
    chk("bank", bank_status_o, 1'b0);
    host_u.bank(1'b1, 4'h6);
    op(1'b0, 4'hb, 1'b0, 16'h0000);
    chk("cfg", io_rdata_o[7:0], {1'b1, adc_cfg_low_i});
    op(1'b1, 4'hf, 1'b0, 16'h0012);
    chk("ctl", {counter_ctrl_wr_o, counter_mode_o}, 7'h08);
    op(1'b1, 4'he, 1'b0, 16'h0010);
    host_u.cyc(1'b1, 4'hc, 1'b1, 16'hbeef);
    host_u.cyc(1'b1, 4'hd, 1'b0, 16'h0077);
    op(1'b1, 4'hc, 1'b0, 16'h0066);
    chk("arr", {array_wr_o, array_lanes_o, array_addr_o, array_wdata_o, counter_wr_o},
      {1'b1, 2'h1, 8'h13, 16'h6666, 3'h0});
    auto_advance_inhibit_i = 1'b1;
    op(1'b1, 4'hd, 1'b0, 16'h0044);
    chk("aad", array_addr_o, 8'h14);
    op(1'b0, 4'he, 1'b0, 16'h0000);
    chk("ptr", io_rdata_o[7:0], 8'h14);
    auto_advance_inhibit_i = 1'b0;
    op(1'b0, 4'hc, 1'b1, 16'h0000);
    chk("ard", {array_rd_o, counter_rd_o, array_lanes_o, io_rdata_o},
      {1'b1, 3'h0, 2'h3, 16'hcafe});
    host_u.bank(1'b0, 4'h6);
    op(1'b1, 4'he, 1'b0, 16'h0099);
    chk("cwr", {bank_status_o, counter_wr_o, array_wr_o}, {1'b0, 3'h4, 1'b0});
    host_u.bank(1'b1, 4'h0);
    rst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk("rst", {bank_status_o, counter_mode_o}, {1'b0, 6'h01});
    summarize();
  end
endmodule
